// ===== dv/lpf_phy_model.sv
// Behavioural model of the attached PHY register port.
`default_nettype none
module lpf_phy_model
    import lpf_pkg::*;
(
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_i,
    // Extra wait before accepting a request.
    input wire logic [1:0] slow_i,
    // Register requests from the link.
    input wire logic req_valid_i,
    input wire lpf_phy_req_t req_i,
    output logic ready_o,
    // Register transfers to the link.
    output logic rx_valid_o,
    output var lpf_phy_rx_t rx_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] regs_r [16];
    logic [1:0] wait_r;
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ready_o <= 1'b0;
            wait_r <= 2'h0;
            rx_valid_o <= 1'b0;
            rx_o <= '0;
            for (int i = 0; i < 16; i++) regs_r[i] <= 8'h5a ^ 8'(i);
        end else begin
            rx_valid_o <= 1'b0;
            // Outside a transfer the lines wander, so stale data is never mistaken for fresh.
            rx_o <= ~rx_o;
            if (req_valid_i && !ready_o) begin
                wait_r <= wait_r + 2'h1;
                ready_o <= (wait_r >= slow_i);
            end else begin
                wait_r <= 2'h0;
                ready_o <= 1'b0;
            end
            if (req_valid_i && ready_o && req_i.write) begin
                regs_r[req_i.addr] <= req_i.data;
            end else if (req_valid_i && ready_o) begin
                rx_valid_o <= 1'b1;
                rx_o <= {req_i.addr, regs_r[req_i.addr]};
            end
        end
    end
endmodule : lpf_phy_model
`default_nettype wire

// ===== dv/lpf_top_test.sv
// Self-checking bench for the PHY access port, cycle timer and request filter.
`default_nettype none
module lpf_top_test import lpf_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, rd_seen = 0, cyc_en = 0;
    logic phy_req_valid_o, phy_req_ready_i, phy_rx_valid_i, cyc_clk_i = 0, ext_8k_i = 0;
    logic cs_rx_valid_i = 0, cs_tx_valid_o, chk_valid_i = 0, chk_filtered_ctx_i = 0;
    logic chk_done_o, chk_accept_o, chk_low_node_o;
    logic [11:0] reg_addr_i = 0;
    logic [31:0] reg_wdata_i = 0, reg_rdata_o, jk, fs, fc, filt, v;
    logic [9:0] local_bus_i = 10'h155;
    logic [1:0] slow = 0;
    logic [3:0] ta, ra = 0;
    logic [7:0] wd, rv = 0;
    lpf_phy_req_t phy_req_o;
    lpf_phy_rx_t phy_rx_i;
    lpf_cycle_time_t cs_rx_data_i = '0, cs_tx_data_o;
    lpf_node_id_t chk_src_i = '0;
    int mismatches = 0, checks_done = 0, cycles = 0;
    logic [31:0] rq[$], cq[$];
    logic [1:0] fq[$];
    lpf_top i_dut (.mclk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o, .phy_req_valid_o, .phy_req_o, .phy_req_ready_i, .phy_rx_valid_i,
        .phy_rx_i, .cyc_clk_i, .ext_8k_i, .cs_rx_valid_i, .cs_rx_data_i, .cs_tx_valid_o,
        .cs_tx_data_o, .chk_valid_i, .chk_filtered_ctx_i, .chk_src_i, .local_bus_i,
        .chk_done_o, .chk_accept_o, .chk_low_node_o);
    lpf_phy_model i_phy (.mclk_i, .rst_i, .slow_i(slow), .req_valid_i(phy_req_valid_o),
        .req_i(phy_req_o), .ready_o(phy_req_ready_i), .rx_valid_o(phy_rx_valid_i),
        .rx_o(phy_rx_i));
    always #2 mclk_i = ~mclk_i;
    always #20 if (cyc_en) cyc_clk_i = ~cyc_clk_i;
    task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic cmp_rd(logic [31:0] exp);
        cmp("reg_rdata_o", exp, reg_rdata_o);
    endtask : cmp_rd
    task automatic cmp_chk(logic [1:0] exp);
        cmp("chk_accept_o,chk_low_node_o", 32'(exp), 32'({chk_accept_o, chk_low_node_o}));
    endtask : cmp_chk
    task automatic cmp_cs(logic [31:0] exp);
        cmp("cs_tx_data_o", exp, cs_tx_data_o);
    endtask : cmp_cs
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    task automatic wr(logic [11:0] a, logic [31:0] d);
        reg_wr_i <= 1'b1;
        reg_rd_i <= 1'b0;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge mclk_i);
    endtask : wr
    task automatic rd(logic [11:0] a, logic [31:0] e);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        rq.push_back(e);
        @(posedge mclk_i);
    endtask : rd
    task automatic idle(int n);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        chk_valid_i <= 1'b0;
        cs_rx_valid_i <= 1'b0;
        repeat (n) @(posedge mclk_i);
    endtask : idle
    task automatic chk(logic f, logic [9:0] b, logic [5:0] n, logic [1:0] e);
        chk_valid_i <= 1'b1;
        chk_filtered_ctx_i <= f;
        chk_src_i <= {b, n};
        fq.push_back(e);
        @(posedge mclk_i);
    endtask : chk
    task automatic cs_in(lpf_cycle_time_t d);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        cs_rx_valid_i <= 1'b1;
        cs_rx_data_i <= d;
        @(posedge mclk_i);
        cs_rx_valid_i <= 1'b0;
    endtask : cs_in
    always @(posedge mclk_i) begin
        if (rd_seen) cmp_rd(rq.pop_front());
        rd_seen <= reg_rd_i;
        if (chk_done_o === 1'b1) cmp_chk(fq.pop_front());
        if (cs_tx_valid_o === 1'b1) cmp_cs(cq.size() > 0 ? cq.pop_front() : 32'hx);
    end
    // Bounds the run so a stuck handshake still reaches the verdict.
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles > 5000) begin
            mismatches++;
            close_out();
        end
    end
    initial begin
        void'($urandom(32'h9141));
        repeat (6) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        rd(OFS_PHY_ACCESS, 32'h0);
        rd(OFS_FILT_CLR, FILT_RESET);
        rd(12'h0f8, 32'h0);
        idle(2);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            ta = 4'($urandom());
            wd = 8'($urandom());
            jk = $urandom() & 32'hffff_3000;
            slow <= 2'(i);
            wr(OFS_PHY_ACCESS, jk | {16'h0, 4'h4, ta, wd});
            rd(OFS_PHY_ACCESS, {4'h0, ra, rv, 4'h4, ta, wd});
            idle(1);
            for (int k = 0; k < 20 && phy_req_valid_o !== 1'b0; k++) @(posedge mclk_i);
            rd(OFS_PHY_ACCESS, {4'h0, ra, rv, 4'h0, ta, wd});
            wr(OFS_PHY_ACCESS, {16'h0, 4'h8, ta, wd});
            rd(OFS_PHY_ACCESS, {4'h0, ra, rv, 4'h8, ta, wd});
            idle(1);
            for (int k = 0; k < 20 && phy_rx_valid_i !== 1'b1; k++) @(posedge mclk_i);
            @(posedge mclk_i);
            ra = ta;
            rv = wd;
            rd(OFS_PHY_ACCESS, {1'b1, 3'h0, ra, rv, 4'h0, ta, wd});
            idle(1);
        end
        $display("test phy access done");
        fs = $urandom();
        fc = $urandom();
        filt = fs & ~fc;
        wr(OFS_FILT_SET, fs);
        wr(OFS_FILT_CLR, fc);
        rd(OFS_FILT_SET, filt);
        rd(OFS_FILT_CLR, filt);
        idle(1);
        for (int n = 0; n < 64; n++)
            chk(1'b1, local_bus_i, 6'(n),
                n < 32 ? 2'b01 : {n < 63 && filt[n - 32], 1'b0});
        for (int j = 0; j < 2; j++) begin
            idle(1);
            wr(j ? OFS_FILT_SET : OFS_FILT_CLR, 32'h8000_0000);
            idle(1);
            chk(1'b1, ~local_bus_i, 6'($urandom()), {j[0], 1'b0});
            chk(1'b0, ~local_bus_i, 6'($urandom()), 2'b10);
        end
        idle(3);
        $display("test filter done");
        wr(OFS_TIMER_CTRL, 32'h3);
        wr(OFS_CYCLE_TIME, {7'h7f, 13'd7999, 12'd3069});
        cq.push_back(32'h0);
        idle(1);
        cyc_en = 1;
        for (int k = 0; k < 400 && cq.size() > 0; k++) @(posedge mclk_i);
        cyc_en = 0;
        cmp("cs_tx pending", 32'h0, 32'(cq.size()));
        wr(OFS_TIMER_CTRL, 32'h0);
        v = {7'($urandom()), 13'($urandom() % 8000), 12'($urandom() % 3072)};
        wr(OFS_CYCLE_TIME, v);
        rd(OFS_CYCLE_TIME, v);
        v = {7'($urandom()), 13'($urandom() % 8000), 12'($urandom() % 3072)};
        cs_in(v);
        rd(OFS_CYCLE_TIME, v);
        wr(OFS_TIMER_CTRL, 32'h1);
        cs_in(~v);
        rd(OFS_CYCLE_TIME, v);
        wr(OFS_TIMER_CTRL, 32'h6);
        wr(OFS_CYCLE_TIME, {7'd5, 13'd7999, 12'd100});
        idle(1);
        ext_8k_i <= 1'b1;
        idle(6);
        ext_8k_i <= 1'b0;
        idle(2);
        rd(OFS_CYCLE_TIME, {7'd6, 13'd0, 12'd0});
        idle(3);
        $display("test cycle timer done");
        close_out();
    end
endmodule : lpf_top_test
`default_nettype wire

// ===== inc/lpf_pkg.sv
// Package with register map, field layout and timing constants for this block.
`default_nettype none
package lpf_pkg;
    // Register byte offsets.
    localparam logic [11:0] OFS_PHY_ACCESS = 12'h0ec;
    localparam logic [11:0] OFS_CYCLE_TIME = 12'h0f0;
    localparam logic [11:0] OFS_FILT_SET = 12'h100;
    localparam logic [11:0] OFS_FILT_CLR = 12'h104;
    localparam logic [11:0] OFS_TIMER_CTRL = 12'h110;
    // Field positions of the PHY access register.
    localparam int PA_DONE_BIT = 31;
    localparam int PA_RADDR_LSB = 24;
    localparam int PA_RDATA_LSB = 16;
    localparam int PA_RDREQ_BIT = 15;
    localparam int PA_WRREQ_BIT = 14;
    localparam int PA_TADDR_LSB = 8;
    localparam int PA_WDATA_LSB = 0;
    // Field positions of the timer control register.
    localparam int TC_MASTER_BIT = 0;
    localparam int TC_RUN_BIT = 1;
    localparam int TC_EXT8K_BIT = 2;
    // Reset values.
    localparam logic [31:0] FILT_RESET = 32'h0000_0000;
    localparam logic [31:0] TIME_RESET = 32'h0000_0000;
    localparam logic [3:0] TADDR_RESET = 4'h0;
    localparam logic [7:0] WDATA_RESET = 8'h00;
    localparam logic [2:0] TCTRL_RESET = 3'h0;
    // Timer moduli and filter layout.
    localparam logic [11:0] OFFSET_MAX = 12'hbff;
    localparam logic [12:0] COUNT_MAX = 13'h1f3f;
    localparam int ALL_BUSES_BIT = 31;
    localparam logic [5:0] FILT_NODE_LO = 6'h20;
    localparam logic [5:0] FILT_NODE_HI = 6'h3e;

    typedef struct packed {
        logic [6:0] seconds;
        logic [12:0] count;
        logic [11:0] offset;
    } lpf_cycle_time_t;

    typedef struct packed {
        logic write;
        logic [3:0] addr;
        logic [7:0] data;
    } lpf_phy_req_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] data;
    } lpf_phy_rx_t;

    typedef struct packed {
        logic [9:0] bus_identifier;
        logic [5:0] local_node_index;
    } lpf_node_id_t;
endpackage : lpf_pkg
`default_nettype wire

// ===== rtl/lpf_cycle_timer.sv
// Isochronous cycle timer: offset, cycle number and seconds counters.
`default_nettype none
module lpf_cycle_timer
    import lpf_pkg::*;
(
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_i,
    // Timing events, one cycle pulses.
    input wire logic tick_i,
    input wire logic ext_tick_i,
    // Configuration levels.
    input wire logic run_i,
    input wire logic ext_mode_i,
    // Loads.
    input wire logic sw_wr_i,
    input wire lpf_cycle_time_t sw_data_i,
    input wire logic cs_load_i,
    input wire lpf_cycle_time_t cs_data_i,
    // Results.
    output var lpf_cycle_time_t time_o,
    output logic wrap_o
);
    lpf_cycle_time_t time_r;
    logic adv;
    logic off_wrap;

    assign off_wrap = ext_mode_i ? ext_tick_i : (tick_i && time_r.offset == OFFSET_MAX);
    assign adv = run_i && off_wrap && !sw_wr_i && !cs_load_i;
    assign wrap_o = adv;
    assign time_o = time_r;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            time_r <= TIME_RESET;
        end else if (sw_wr_i) begin
            time_r <= sw_data_i;
        end else if (cs_load_i) begin
            time_r <= cs_data_i;
        end else if (adv) begin
            time_r.offset <= 12'h000;
            if (time_r.count == COUNT_MAX) begin
                time_r.count <= 13'h0000;
                time_r.seconds <= time_r.seconds + 7'h01;
            end else begin
                time_r.count <= time_r.count + 13'h0001;
            end
        end else if (run_i && tick_i) begin
            // Between external ticks the offset keeps counting but never wraps on its own.
            if (!ext_mode_i || time_r.offset != OFFSET_MAX) begin
                time_r.offset <= time_r.offset + 12'h001;
            end
        end
    end

    sequence s_quiet;
        !sw_wr_i && !cs_load_i;
    endsequence

    property p_offset_wrap;
        @(posedge mclk_i) disable iff (rst_i)
        s_quiet and (run_i && !ext_mode_i && tick_i && time_r.offset == OFFSET_MAX)
        |=> time_r.offset == 12'h000 && time_r.count != $past(time_r.count);
    endproperty
    a_offset_wrap: assert property (p_offset_wrap) else $error("offset did not wrap");

    property p_count_wrap;
        @(posedge mclk_i) disable iff (rst_i)
        adv && time_r.count == COUNT_MAX
        |=> time_r.count == 13'h0000 && time_r.seconds == $past(time_r.seconds) + 7'h01;
    endproperty
    a_count_wrap: assert property (p_count_wrap) else $error("count did not wrap");

    property p_ext_clear;
        @(posedge mclk_i) disable iff (rst_i)
        s_quiet and (run_i && ext_mode_i && ext_tick_i) |=> time_r.offset == 12'h000;
    endproperty
    a_ext_clear: assert property (p_ext_clear) else $error("offset not cleared");

    property p_cs_load;
        @(posedge mclk_i) disable iff (rst_i)
        !sw_wr_i && cs_load_i |=> time_r == $past(cs_data_i);
    endproperty
    a_cs_load: assert property (p_cs_load) else $error("cycle start not loaded");

    property p_hold_stopped;
        @(posedge mclk_i) disable iff (rst_i)
        s_quiet and !run_i |=> time_r == $past(time_r);
    endproperty
    a_hold_stopped: assert property (p_hold_stopped) else $error("timer moved");
endmodule : lpf_cycle_timer
`default_nettype wire

// ===== rtl/lpf_top.sv
// Link register bank: PHY register access port, cycle timer and upper node request filter.
//
// Function
// - Setting read or write request clears the read-complete flag.
// - A register transfer from the PHY sets the read-complete flag.
// - The readback address holds the address of the latest PHY transfer.
// - The readback value holds the eight data bits from the PHY.
// - Software starts a read; hardware clears the read request once sent.
// - Software starts a write; hardware clears the write request once sent.
// - A four-bit writable target address, reset zero, selects the PHY register.
// - Eight-bit write value, reset zero, goes out on writes, ignored on reads.
// - Reserved bits of the PHY access register read as zero.
// - As cycle master the timer value is the cycle start payload.
// - When not master, incoming cycle starts load the timer.
// - Without cycle starts the timer may keep counting when enabled.
// - Offset counts cycle clock ticks modulo 3072.
// - Offset wraps advance the cycle number modulo 8000.
// - Cycle number wraps advance seconds modulo 128; all fields writable.
// - In external 8 kHz mode each external tick clears the offset.
// - Filtered-context requests from disabled source nodes are neither acked nor queued.
// - Per-node comparison applies only to sources on the local bus.
// - Nonlocal requests are refused unless the all-buses bit is set.
// - Filter has set and clear addresses, ones act, resets to zero.
// - Filter bits 30 to 0 enable local nodes 62 to 32.
// - Node identity is a 10-bit bus number over a 6-bit node number.
`default_nettype none
module lpf_top
    import lpf_pkg::*;
(
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_i,
    // Register port.
    input wire logic [11:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // PHY register request and register transfer.
    output logic phy_req_valid_o,
    output var lpf_phy_req_t phy_req_o,
    input wire logic phy_req_ready_i,
    input wire logic phy_rx_valid_i,
    input wire lpf_phy_rx_t phy_rx_i,
    // Cycle clock pins.
    input wire logic cyc_clk_i,
    input wire logic ext_8k_i,
    // Cycle start messages.
    input wire logic cs_rx_valid_i,
    input wire lpf_cycle_time_t cs_rx_data_i,
    output logic cs_tx_valid_o,
    output var lpf_cycle_time_t cs_tx_data_o,
    // Asynchronous request check.
    input wire logic chk_valid_i,
    input wire logic chk_filtered_ctx_i,
    input wire lpf_node_id_t chk_src_i,
    input wire logic [9:0] local_bus_i,
    output logic chk_done_o,
    output logic chk_accept_o,
    output logic chk_low_node_o
);
    // PHY access state.
    logic phy_read_complete_r;
    logic [3:0] phy_readback_address_r;
    logic [7:0] phy_readback_value_r;
    logic phy_read_request_r;
    logic phy_write_request_r;
    logic [3:0] phy_target_address_r;
    logic [7:0] phy_write_value_r;
    // Filter and timer control.
    logic [31:0] filt_r;
    logic [2:0] tctrl_r;
    // Register port.
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic pa_wr;
    logic ct_wr;
    logic fs_wr;
    logic fc_wr;
    logic tc_wr;
    logic req_sent;
    logic [31:0] phy_access_word;
    // Pin synchronisers.
    logic cyc_s1_r;
    logic cyc_s2_r;
    logic cyc_s3_r;
    logic e8k_s1_r;
    logic e8k_s2_r;
    logic e8k_s3_r;
    logic cyc_tick;
    logic e8k_tick;
    // Timer.
    lpf_cycle_time_t time_cur;
    logic time_wrap;
    logic cs_tx_valid_r;
    // Filter decision.
    logic chk_local;
    logic chk_in_upper;
    logic [4:0] chk_bit;
    logic chk_accept_nxt;
    logic chk_done_r;
    logic chk_accept_r;
    logic chk_low_r;

    // Address decode.
    always_comb begin
        pa_wr = 1'b0;
        ct_wr = 1'b0;
        fs_wr = 1'b0;
        fc_wr = 1'b0;
        tc_wr = 1'b0;
        if (reg_wr_i && reg_addr_i == OFS_PHY_ACCESS) begin
            pa_wr = 1'b1;
        end else if (reg_wr_i && reg_addr_i == OFS_CYCLE_TIME) begin
            ct_wr = 1'b1;
        end else if (reg_wr_i && reg_addr_i == OFS_FILT_SET) begin
            fs_wr = 1'b1;
        end else if (reg_wr_i && reg_addr_i == OFS_FILT_CLR) begin
            fc_wr = 1'b1;
        end else if (reg_wr_i && reg_addr_i == OFS_TIMER_CTRL) begin
            tc_wr = 1'b1;
        end
    end

    // Reserved fields are hard zeros in the assembled word.
    always_comb begin
        phy_access_word = 32'h0000_0000;
        phy_access_word[PA_DONE_BIT] = phy_read_complete_r;
        phy_access_word[PA_RADDR_LSB +: 4] = phy_readback_address_r;
        phy_access_word[PA_RDATA_LSB +: 8] = phy_readback_value_r;
        phy_access_word[PA_RDREQ_BIT] = phy_read_request_r;
        phy_access_word[PA_WRREQ_BIT] = phy_write_request_r;
        phy_access_word[PA_TADDR_LSB +: 4] = phy_target_address_r;
        phy_access_word[PA_WDATA_LSB +: 8] = phy_write_value_r;
    end

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (reg_addr_i == OFS_PHY_ACCESS) begin
            rdata_nxt = phy_access_word;
        end else if (reg_addr_i == OFS_CYCLE_TIME) begin
            rdata_nxt = time_cur;
        end else if (reg_addr_i == OFS_FILT_SET || reg_addr_i == OFS_FILT_CLR) begin
            rdata_nxt = filt_r;
        end else if (reg_addr_i == OFS_TIMER_CTRL) begin
            rdata_nxt = {29'h0000_0000, tctrl_r};
        end
    end

    // Read data stand only in the cycle after the strobe; otherwise the port shows zero.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_r <= 32'h0000_0000;
        end else if (reg_rd_i) begin
            rdata_r <= rdata_nxt;
        end else begin
            rdata_r <= 32'h0000_0000;
        end
    end
    assign reg_rdata_o = rdata_r;

    // PHY request handshake; the request flops hold until the PHY side takes it.
    assign req_sent = phy_req_valid_o && phy_req_ready_i;
    assign phy_req_valid_o = phy_read_request_r || phy_write_request_r;
    // A read wins if software breaks the one-request-at-a-time contract.
    assign phy_req_o.write = phy_write_request_r && !phy_read_request_r;
    assign phy_req_o.addr = phy_target_address_r;
    assign phy_req_o.data = phy_req_o.write ? phy_write_value_r : 8'h00;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            phy_target_address_r <= TADDR_RESET;
            phy_write_value_r <= WDATA_RESET;
        end else if (pa_wr) begin
            phy_target_address_r <= reg_wdata_i[PA_TADDR_LSB +: 4];
            phy_write_value_r <= reg_wdata_i[PA_WDATA_LSB +: 8];
        end
    end

    // A software write in the same cycle as the send starts a new request and wins.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            phy_read_request_r <= 1'b0;
            phy_write_request_r <= 1'b0;
        end else if (pa_wr) begin
            phy_read_request_r <= reg_wdata_i[PA_RDREQ_BIT];
            phy_write_request_r <= reg_wdata_i[PA_WRREQ_BIT];
        end else if (req_sent) begin
            phy_read_request_r <= 1'b0;
            phy_write_request_r <= 1'b0;
        end
    end

    // The arriving transfer wins over the clear so that no completion is lost.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            phy_read_complete_r <= 1'b0;
        end else if (phy_rx_valid_i) begin
            phy_read_complete_r <= 1'b1;
        end else if (pa_wr && (reg_wdata_i[PA_RDREQ_BIT] || reg_wdata_i[PA_WRREQ_BIT])) begin
            phy_read_complete_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            phy_readback_address_r <= 4'h0;
            phy_readback_value_r <= 8'h00;
        end else if (phy_rx_valid_i) begin
            phy_readback_address_r <= phy_rx_i.addr;
            phy_readback_value_r <= phy_rx_i.data;
        end
    end

    // Upper node filter: ones written at the set address set, at the clear address clear.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            filt_r <= FILT_RESET;
        end else if (fs_wr) begin
            filt_r <= filt_r | reg_wdata_i;
        end else if (fc_wr) begin
            filt_r <= filt_r & ~reg_wdata_i;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            tctrl_r <= TCTRL_RESET;
        end else if (tc_wr) begin
            tctrl_r <= reg_wdata_i[2:0];
        end
    end

    // Cycle clock and 8 kHz pins are asynchronous; only the second and third stages feed edge logic.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cyc_s1_r <= 1'b0;
            cyc_s2_r <= 1'b0;
            cyc_s3_r <= 1'b0;
            e8k_s1_r <= 1'b0;
            e8k_s2_r <= 1'b0;
            e8k_s3_r <= 1'b0;
        end else begin
            cyc_s1_r <= cyc_clk_i;
            cyc_s2_r <= cyc_s1_r;
            cyc_s3_r <= cyc_s2_r;
            e8k_s1_r <= ext_8k_i;
            e8k_s2_r <= e8k_s1_r;
            e8k_s3_r <= e8k_s2_r;
        end
    end
    assign cyc_tick = cyc_s2_r && !cyc_s3_r;
    assign e8k_tick = e8k_s2_r && !e8k_s3_r;

    lpf_cycle_timer u_timer (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .tick_i(cyc_tick),
        .ext_tick_i(e8k_tick),
        .run_i(tctrl_r[TC_RUN_BIT]),
        .ext_mode_i(tctrl_r[TC_EXT8K_BIT]),
        .sw_wr_i(ct_wr),
        .sw_data_i(reg_wdata_i),
        .cs_load_i(cs_rx_valid_i && !tctrl_r[TC_MASTER_BIT]),
        .cs_data_i(cs_rx_data_i),
        .time_o(time_cur),
        .wrap_o(time_wrap)
    );

    // The pulse follows the wrap, so the payload already shows the new cycle at offset zero.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cs_tx_valid_r <= 1'b0;
        end else begin
            cs_tx_valid_r <= time_wrap && tctrl_r[TC_MASTER_BIT];
        end
    end
    assign cs_tx_valid_o = cs_tx_valid_r;
    assign cs_tx_data_o = time_cur;

    // Request filter decision, one cycle after the check strobe.
    assign chk_local = chk_src_i.bus_identifier == local_bus_i;
    assign chk_in_upper = chk_src_i.local_node_index >= FILT_NODE_LO &&
                          chk_src_i.local_node_index <= FILT_NODE_HI;
    assign chk_bit = chk_src_i.local_node_index[4:0];

    always_comb begin
        if (!chk_filtered_ctx_i) begin
            chk_accept_nxt = 1'b1;
        end else if (!chk_local) begin
            chk_accept_nxt = filt_r[ALL_BUSES_BIT];
        end else if (chk_in_upper) begin
            chk_accept_nxt = filt_r[chk_bit];
        end else begin
            chk_accept_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            chk_done_r <= 1'b0;
            chk_accept_r <= 1'b0;
            chk_low_r <= 1'b0;
        end else begin
            chk_done_r <= chk_valid_i;
            chk_accept_r <= chk_valid_i && chk_accept_nxt;
            chk_low_r <= chk_valid_i && chk_filtered_ctx_i && chk_local &&
                         chk_src_i.local_node_index < FILT_NODE_LO;
        end
    end
    assign chk_done_o = chk_done_r;
    assign chk_accept_o = chk_accept_r;
    assign chk_low_node_o = chk_low_r;

    sequence s_req_written;
        pa_wr && (reg_wdata_i[PA_RDREQ_BIT] || reg_wdata_i[PA_WRREQ_BIT]) && !phy_rx_valid_i;
    endsequence

    property p_done_clear;
        @(posedge mclk_i) disable iff (rst_i)
        s_req_written |=> !phy_read_complete_r;
    endproperty
    a_done_clear: assert property (p_done_clear) else $error("done not cleared");

    property p_done_set;
        @(posedge mclk_i) disable iff (rst_i)
        phy_rx_valid_i |=> phy_read_complete_r && phy_readback_value_r == $past(phy_rx_i.data);
    endproperty
    a_done_set: assert property (p_done_set) else $error("done or data not set");

    property p_rb_addr;
        @(posedge mclk_i) disable iff (rst_i)
        phy_rx_valid_i ##1 !phy_rx_valid_i[*2]
        |-> phy_readback_address_r == $past(phy_rx_i.addr, 2);
    endproperty
    a_rb_addr: assert property (p_rb_addr) else $error("readback address lost");

    property p_sent_clears;
        @(posedge mclk_i) disable iff (rst_i)
        req_sent && !pa_wr |=> !phy_req_valid_o;
    endproperty
    a_sent_clears: assert property (p_sent_clears) else $error("request not cleared");

    property p_held_until_sent;
        @(posedge mclk_i) disable iff (rst_i)
        phy_req_valid_o && !phy_req_ready_i && !pa_wr |=> phy_req_valid_o;
    endproperty
    a_held_until_sent: assert property (p_held_until_sent) else $error("req dropped");

    property p_reserved_zero;
        @(posedge mclk_i) disable iff (rst_i)
        reg_rd_i && reg_addr_i == OFS_PHY_ACCESS
        |=> reg_rdata_o[30:28] == 3'h0 && reg_rdata_o[13:12] == 2'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved set");

    property p_cs_tx;
        @(posedge mclk_i) disable iff (rst_i)
        time_wrap && tctrl_r[TC_MASTER_BIT] |=> cs_tx_valid_o && cs_tx_data_o.offset == 12'h000;
    endproperty
    a_cs_tx: assert property (p_cs_tx) else $error("cycle start not sent");

    property p_nonlocal;
        @(posedge mclk_i) disable iff (rst_i)
        chk_valid_i && chk_filtered_ctx_i && !chk_local
        |=> chk_accept_o == $past(filt_r[ALL_BUSES_BIT]);
    endproperty
    a_nonlocal: assert property (p_nonlocal) else $error("nonlocal decision wrong");

    property p_filter_set;
        @(posedge mclk_i) disable iff (rst_i)
        fs_wr |=> (filt_r & $past(reg_wdata_i)) == $past(reg_wdata_i);
    endproperty
    a_filter_set: assert property (p_filter_set) else $error("filter set failed");
endmodule : lpf_top
`default_nettype wire
